// ==== logic/sapi_core.sv ====
// Contract
// - strobe fall starts conversion, samples inputs
// - converting begins at next conversion-clock rise
// - conversion lasts 13.5 conversion-clock cycles
// - 2.5 cycles reserved for input acquisition
// - busy falls about 20ns after strobe
// - busy rises only with result valid
// - channel taken on strobe rise, chip-select low
// - result straight binary, msb first
// - bus driven only with select, read low
// - data valid 30ns after read fall
// - read rise applies addressed power state
// - low address bits: 00 run, 01 nap, 1x sleep
// - select tied low: read alone controls power
// - nap keeps reference, next results valid
// - sleep powers off, ten results may be spurious
// - new conversion leaves any power-down mode
// - select and strobe low float data outputs
`timescale 1ns/100ps
`default_nettype none

module sapi_core (
  input wire logic ref_clk_in, // system clock, 100 MHz
  input wire logic sys_rst_in, // synchronous reset, active high
  input wire logic conv_clk_in, // external conversion clock, sampled
  input wire logic wr_n_in, // conversion strobe, active low
  input wire logic cs_n_in, // chip select, active low
  input wire logic rd_n_in, // read strobe, active low
  input wire logic [2:0] chan_sel_in, // chan_sel_2..chan_sel_0
  input wire logic [11:0] sar_code_in, // comparator decisions from analog core
  output logic [11:0] result_out, // result bus, msb at bit 11, result_bit_lsb at bit 0
  output logic result_oe_out, // high while result bus is driven
  output logic busy_out, // low while converting
  output logic [2:0] chan_active_out, // channel connected to sampler
  output logic [1:0] pwr_state_out, // 0 normal, 1 nap, 2 sleep
  output logic ref_on_out, // reference powered
  output logic core_on_out, // converter core powered
  output logic result_settling_out // results may be spurious after sleep
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic wr_n_q;
    logic rd_n_q;
    logic clk_q;
    sapi_pkg::sapi_phase_t phase;
    logic [4:0] half_cnt;
    logic busy;
    logic [2:0] chan;
    logic [2:0] start_chan;
    sapi_pkg::sapi_pwr_t pwr;
    logic [3:0] settle_cnt;
    logic [1:0] rd_cnt;
    logic valid;
    sapi_pkg::sapi_word_t buf0;
    sapi_pkg::sapi_word_t buf1;
    logic buf0_v;
    logic buf1_v;
    logic [11:0] result;
    logic [2:0] busy_dly;
  } sapi_state_t;

  sapi_state_t st;
  sapi_state_t next_st;

  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic clk_edge;
  logic conv_done;
  logic buf_in_ready;
  logic buf_out_ready;
  sapi_pkg::sapi_word_t done_word;

  // power decode of the low address bits
  function automatic sapi_pkg::sapi_pwr_t pwr_decode(input logic [1:0] sel);
    case (sel)
      2'h0: pwr_decode = sapi_pkg::SAPI_PWR_NORMAL;
      2'h1: pwr_decode = sapi_pkg::SAPI_PWR_NAP;
      default: pwr_decode = sapi_pkg::SAPI_PWR_SLEEP;
    endcase
  endfunction

  // ****************************************
  // edge detection on host strobes and conversion clock
  // ****************************************
  assign wr_fall = st.wr_n_q && !wr_n_in;
  assign wr_rise = !st.wr_n_q && wr_n_in;
  assign rd_fall = st.rd_n_q && !rd_n_in;
  assign rd_rise = !st.rd_n_q && rd_n_in;
  assign clk_edge = st.clk_q != conv_clk_in; // both edges count half cycles
  assign conv_done = (st.phase == sapi_pkg::SAPI_CONV) && clk_edge && (st.half_cnt == sapi_pkg::CONV_HALF_LAST);
  assign done_word = '{code: sar_code_in, chan: st.start_chan, settling: st.settle_cnt != 4'h0};
  assign buf_in_ready = !st.buf1_v;
  assign buf_out_ready = 1'b1; // output latch always accepts

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.wr_n_q = wr_n_in;
    next_st.rd_n_q = rd_n_in;
    next_st.clk_q = conv_clk_in;
    next_st.busy_dly = {st.busy_dly[1:0], wr_fall && !cs_n_in};
    // conversion start and frame sequencing
    case (st.phase)
      sapi_pkg::SAPI_IDLE: begin
        if (wr_fall && !cs_n_in) begin
          next_st.phase = sapi_pkg::SAPI_ARMED;
          next_st.start_chan = st.chan;
          if (st.pwr != sapi_pkg::SAPI_PWR_NORMAL) begin
            next_st.pwr = sapi_pkg::SAPI_PWR_NORMAL;
          end
        end
      end
      sapi_pkg::SAPI_ARMED: begin
        if (clk_edge && conv_clk_in) begin
          next_st.phase = sapi_pkg::SAPI_CONV;
          next_st.half_cnt = 5'h00;
        end
      end
      sapi_pkg::SAPI_CONV: begin
        if (clk_edge) begin
          next_st.half_cnt = st.half_cnt + 5'h01;
        end
        if (conv_done) begin
          next_st.phase = sapi_pkg::SAPI_IDLE;
          next_st.half_cnt = 5'h00;
        end
      end
      default: next_st.phase = sapi_pkg::SAPI_IDLE;
    endcase
    // busy falls a fixed delay after the strobe, rises at completion
    if (st.busy_dly[sapi_pkg::BUSY_DELAY_CYC - 1]) begin
      next_st.busy = 1'b0;
    end
    if (st.valid && !st.buf0_v && !st.buf1_v && st.phase == sapi_pkg::SAPI_IDLE && !st.busy) begin
      next_st.busy = 1'b1;
    end
    // channel latched on strobe rise while selected
    if (wr_rise && !cs_n_in) begin
      next_st.chan = chan_sel_in;
    end
    // two-entry buffer between converter and output latch
    next_st.valid = 1'b0;
    if (st.buf0_v && buf_out_ready) begin
      next_st.result = st.buf0.code;
      next_st.buf0 = st.buf1;
      next_st.buf0_v = st.buf1_v;
      next_st.buf1_v = 1'b0;
      next_st.valid = 1'b1;
      if (st.settle_cnt != 4'h0) begin
        next_st.settle_cnt = st.settle_cnt - 4'h1;
      end
    end
    if (conv_done && buf_in_ready) begin
      if (next_st.buf0_v) begin
        next_st.buf1 = done_word;
        next_st.buf1_v = 1'b1;
      end else begin
        next_st.buf0 = done_word;
        next_st.buf0_v = 1'b1;
      end
    end
    // read access timing
    if (!cs_n_in && !rd_n_in) begin
      if (st.rd_cnt != sapi_pkg::DATA_VALID_CNT) begin
        next_st.rd_cnt = st.rd_cnt + 2'h1;
      end
    end else begin
      next_st.rd_cnt = 2'h0;
    end
    // power state applied on read rise
    if (rd_rise && !cs_n_in && st.phase == sapi_pkg::SAPI_IDLE) begin
      next_st.pwr = pwr_decode(chan_sel_in[1:0]);
      if (pwr_decode(chan_sel_in[1:0]) == sapi_pkg::SAPI_PWR_SLEEP) begin
        next_st.settle_cnt = sapi_pkg::SLEEP_SETTLE_CNT;
      end
    end
    if (sys_rst_in) begin
      next_st = '0;
      next_st.wr_n_q = 1'b1;
      next_st.rd_n_q = 1'b1;
      next_st.busy = 1'b1;
      next_st.result = sapi_pkg::RESULT_RST;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    st <= next_st;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign result_out = st.result;
  assign result_oe_out = !cs_n_in && !rd_n_in && !wr_n_in == 1'b0 && st.busy
                         && st.rd_cnt == sapi_pkg::DATA_VALID_CNT;
  assign busy_out = st.busy;
  assign chan_active_out = st.chan;
  assign pwr_state_out = st.pwr;
  assign ref_on_out = st.pwr != sapi_pkg::SAPI_PWR_SLEEP;
  assign core_on_out = st.pwr == sapi_pkg::SAPI_PWR_NORMAL;
  assign result_settling_out = st.settle_cnt != 4'h0;

  // ****************************************
  // checks
  // ****************************************
  busy_fall_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_fall && !cs_n_in && st.phase == sapi_pkg::SAPI_IDLE) |-> ##3 !busy_out)
    else $error("busy did not fall after strobe");

  conv_enter_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st.phase == sapi_pkg::SAPI_ARMED && clk_edge && conv_clk_in) |=> st.phase == sapi_pkg::SAPI_CONV)
    else $error("converting state not entered on clock rise");

  conv_len_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st.phase == sapi_pkg::SAPI_CONV) |-> st.half_cnt <= sapi_pkg::CONV_HALF_LAST)
    else $error("conversion length wrong");

  busy_rise_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(busy_out) |-> (st.phase == sapi_pkg::SAPI_IDLE && !st.buf0_v))
    else $error("busy rose before completion");

  bus_float_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cs_n_in || rd_n_in || !wr_n_in) |-> !result_oe_out)
    else $error("bus driven without read");

  read_valid_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!cs_n_in && !rd_n_in && wr_n_in && busy_out)[*3] |-> ##1 (result_oe_out || !wr_n_in || cs_n_in || rd_n_in))
    else $error("data not valid after read delay");

  chan_take_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_rise && !cs_n_in) |=> chan_active_out == $past(chan_sel_in))
    else $error("channel not taken on strobe rise");

  pwr_apply_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (rd_rise && !cs_n_in && st.phase == sapi_pkg::SAPI_IDLE && chan_sel_in[1:0] == 2'h1)
    |=> pwr_state_out == 2'h1)
    else $error("nap not entered");

  wake_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_fall && !cs_n_in && st.phase == sapi_pkg::SAPI_IDLE) |=> core_on_out)
    else $error("conversion did not wake");

  hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!st.buf0_v) |=> result_out == $past(result_out))
    else $error("result changed without completion");

  // the last half cycle closes the frame
  conv_end_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st.phase == sapi_pkg::SAPI_CONV && clk_edge && st.half_cnt == sapi_pkg::CONV_HALF_LAST) |=> st.phase == sapi_pkg::SAPI_IDLE)
    else $error("conversion frame did not close");

  // armed waits for a conversion-clock rise
  armed_wait_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st.phase == sapi_pkg::SAPI_ARMED && !(clk_edge && conv_clk_in)) |=> st.phase == sapi_pkg::SAPI_ARMED)
    else $error("converting state entered without clock rise");

  // busy stays low once the frame is under way
  busy_low_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st.phase == sapi_pkg::SAPI_CONV && st.half_cnt != 5'h00) |-> !busy_out)
    else $error("busy high while converting");

  // result latch takes the decisions of the last half cycle
  result_take_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    conv_done |=> ##1 result_out == $past(sar_code_in, 2))
    else $error("result not latched from decisions");

  // busy returns high once the result stands
  busy_done_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    conv_done |-> ##3 busy_out)
    else $error("busy did not rise after completion");

  // the channel of a conversion is the one latched before it
  start_chan_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_fall && !cs_n_in && st.phase == sapi_pkg::SAPI_IDLE) |=> st.start_chan == $past(st.chan))
    else $error("conversion channel not taken at start");

  // a strobe during a frame starts nothing
  no_restart_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st.phase == sapi_pkg::SAPI_CONV && wr_fall && !cs_n_in) |=> st.phase != sapi_pkg::SAPI_ARMED)
    else $error("start accepted while converting");

  // the channel only moves on a selected strobe rise
  chan_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !(wr_rise && !cs_n_in) |=> chan_active_out == $past(chan_active_out))
    else $error("channel changed without strobe rise");

  // ****************************************
  // checks on the read and power path
  // ****************************************

  // the bus is only driven once the result stands
  oe_busy_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    result_oe_out |-> busy_out)
    else $error("bus driven while converting");

  // the bus turns on only after the access delay
  oe_delay_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(result_oe_out) |-> $past(!cs_n_in && !rd_n_in, 3))
    else $error("bus driven before access delay");

  // a read rise during a frame leaves power alone
  pwr_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (rd_rise && st.phase != sapi_pkg::SAPI_IDLE && !wr_fall) |=> pwr_state_out == $past(pwr_state_out))
    else $error("power changed during conversion");

  // sleep selection arms the settling count
  sleep_set_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (rd_rise && !cs_n_in && st.phase == sapi_pkg::SAPI_IDLE && chan_sel_in[1])
    |=> (pwr_state_out == sapi_pkg::SAPI_PWR_SLEEP && result_settling_out))
    else $error("sleep not entered");

  // nap keeps only the reference
  nap_power_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (pwr_state_out == sapi_pkg::SAPI_PWR_NAP) |-> (ref_on_out && !core_on_out))
    else $error("nap power wrong");

  // sleep turns everything off
  sleep_power_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (pwr_state_out == sapi_pkg::SAPI_PWR_SLEEP) |-> (!ref_on_out && !core_on_out))
    else $error("sleep power wrong");

endmodule // sapi_core

`default_nettype wire

// ==== logic/sapi_pkg.sv ====
package sapi_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUSY_DELAY_NS = 20;
  localparam int BUSY_DELAY_CYC = (BUSY_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (BUSY_DELAY_NS / CLK_PERIOD_NS);
  localparam int DATA_VALID_NS = 30;
  localparam int DATA_VALID_CYC = (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DATA_VALID_CNT = 2'(DATA_VALID_CYC);

  // ****************************************
  // conversion frame, counted in half conversion-clock periods
  // ****************************************
  localparam int CONV_HALF_CYCLES = 27;
  localparam logic [4:0] CONV_HALF_LAST = 5'(CONV_HALF_CYCLES - 1);
  localparam int SAMPLE_HALF_CYCLES = 5;
  localparam int LSB_HALF_CYCLES = 3;
  localparam int BIT5_HALF_CYCLES = 4;
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 3;
  localparam int SLEEP_SETTLE_CONV = 10;
  localparam logic [3:0] SLEEP_SETTLE_CNT = 4'(SLEEP_SETTLE_CONV);
  localparam logic [11:0] RESULT_RST = 12'h000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {SAPI_PWR_NORMAL, SAPI_PWR_NAP, SAPI_PWR_SLEEP} sapi_pwr_t;
  typedef enum logic [1:0] {SAPI_IDLE, SAPI_ARMED, SAPI_CONV} sapi_phase_t;

  typedef struct packed {
    logic [11:0] code;
    logic [2:0] chan;
    logic settling;
  } sapi_word_t;

endpackage : sapi_pkg

// ==== verification/sapi_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// conversion clock and analog decision source
// ****************************************
module sapi_far_model #(
  parameter int HALF_NS = 80
) (
  input wire logic busy_in, // converter busy, low while converting
  input wire logic [11:0] code_in, // code the analog side resolves to
  output logic conv_clk_out, // conversion clock
  output logic [11:0] sar_code_out // comparator decisions
);
  // free-running clock at 6.25 MHz, sixteen periods per sample
  initial begin
    conv_clk_out = 1'b0;
    forever #(HALF_NS) conv_clk_out = ~conv_clk_out;
  end

  // decisions only mean something while converting, inverse otherwise
  assign sar_code_out = busy_in ? ~code_in : code_in;
endmodule // sapi_far_model

`default_nettype wire

// ==== verification/tb_sar_adc_parallel_interface.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_sar_adc_parallel_interface;
  logic ref_clk_in, sys_rst_in, wr_n, cs_n, rd_n, conv_clk, busy, oe, ref_on, core_on, settling;
  logic [2:0] chan_sel, chan_act;
  logic [11:0] sar_code, result, code;
  logic [1:0] pwr;
  logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
  logic [2:0] pws [4] = '{3'h0, 3'h1, 3'h6, 3'h3};
  int n_errors = 0;
  int tests_run = 0;

  // ****************************************
  // design and far side
  // ****************************************
  sapi_core uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .conv_clk_in(conv_clk), .wr_n_in(wr_n),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .chan_sel_in(chan_sel), .sar_code_in(sar_code), .result_out(result),
    .result_oe_out(oe), .busy_out(busy), .chan_active_out(chan_act), .pwr_state_out(pwr),
    .ref_on_out(ref_on), .core_on_out(core_on), .result_settling_out(settling));
  sapi_far_model far (.busy_in(busy), .code_in(code), .conv_clk_out(conv_clk), .sar_code_out(sar_code));

  // system clock, 100 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({11'h000, got}, {11'h000, exp}, what);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // start a conversion, try a read and a power change while it runs
  task automatic do_conv(input logic [2:0] ch, input logic [11:0] c);
    int k;
    code = c;
    chan_sel = ch;
    cs_n = 1'b0;
    wr_n = 1'b0;
    rd_n = 1'b0;
    tick(4);
    chk_bit(busy, 1'b0, "busy low after start");
    chk_bit(oe, 1'b0, "bus floats while converting");
    wr_n = 1'b1;
    rd_n = 1'b1;
    tick(2);
    chk_word(12'(chan_act), 12'(ch), "channel latched");
    cs_n = 1'b1;
    for (k = 0; k < 400 && busy !== 1'b1; k++) tick(1);
    chk_bit(k >= 210 && k <= 245, 1'b1, "conversion length");
    chk_word(result, c, "result at busy rise");
    chk_word(12'(pwr), 12'(sapi_pkg::SAPI_PWR_NORMAL), "awake, mid-run change refused");
  endtask

  // read the result and leave the power state coded on the low bits
  task automatic do_read(input logic [2:0] pw);
    sapi_pkg::sapi_pwr_t exp;
    exp = pw[1] ? sapi_pkg::SAPI_PWR_SLEEP : (pw[0] ? sapi_pkg::SAPI_PWR_NAP : sapi_pkg::SAPI_PWR_NORMAL);
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick(3);
    chk_bit(oe, 1'b1, "bus driven");
    chk_word(result, code, "read value held");
    chan_sel = pw;
    tick(1);
    rd_n = 1'b1;
    tick(1);
    cs_n = 1'b1;
    tick(3);
    chk_word(12'(pwr), 12'(exp), "power state");
    chk_bit(ref_on, exp != sapi_pkg::SAPI_PWR_SLEEP, "reference power");
    chk_bit(core_on, exp == sapi_pkg::SAPI_PWR_NORMAL, "core power");
    chk_bit(oe, 1'b0, "bus released");
  endtask

  // chip select tied low: read strobe alone steers power, strobe wakes
  task automatic do_tied();
    cs_n = 1'b0;
    chan_sel = 3'h5;
    wr_n = 1'b0;
    tick(4);
    wr_n = 1'b1;
    for (int k = 0; k < 400 && busy !== 1'b1; k++) tick(1);
    chk_bit(busy, 1'b1, "tied conversion done");
    chk_word(12'(chan_act), 12'h005, "tied channel");
    rd_n = 1'b0;
    tick(3);
    chk_bit(oe, 1'b1, "tied bus driven");
    chk_word(result, code, "tied result");
    chan_sel = 3'h1;
    tick(1);
    rd_n = 1'b1;
    tick(3);
    chk_word(12'(pwr), 12'(sapi_pkg::SAPI_PWR_NAP), "nap by read alone");
    code = 12'hA5C;
    wr_n = 1'b0;
    tick(4);
    chk_bit(core_on, 1'b1, "strobe wakes from nap");
    wr_n = 1'b1;
    for (int k = 0; k < 400 && busy !== 1'b1; k++) tick(1);
    chk_word(result, 12'hA5C, "valid result after nap");
    cs_n = 1'b1;
    tick(2);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_rst_in = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    chan_sel = 3'h0;
    code = 12'h000;
    tick(4);
    chk_bit(busy, 1'b1, "reset busy");
    chk_word(result, 12'h000, "reset result");
    chk_word(12'(pwr), 12'(sapi_pkg::SAPI_PWR_NORMAL), "reset power");
    sys_rst_in = 1'b0;
    tick(2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      do_conv(3'(2 * i + 1), codes[i]);
      chk_bit(settling, i == 3, "settling after sleep");
      do_read(pws[i]);
      $display("test conversion %0d done", i);
    end
    do_read(3'h0);
    $display("test wake by read done");
    do_tied();
    $display("test tied select done");
    print_verdict();
  end

  // watchdog, far beyond the roughly 1500 cycles the tests need
  initial begin
    #200000;
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule // tb_sar_adc_parallel_interface

`default_nettype wire
